// ### rtl/svmx_event_io.sv
// Event, pin-function, reset-pin, fan-control and limit logic of a monitor.
// Assumes all pin inputs are synchronous to sys_clk; open-drain pins are
// resolved outside from the _o/_oe pairs.
`timescale 1ns/1ns
module svmx_event_io
  import svmx_pkg::*;
#(
  parameter int POR_CYCLES = POR_PULSE_US * CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [svmx_pkg::NUM_SHARED-1:0] shared_io_tach_i,
  output logic [svmx_pkg::NUM_SHARED-1:0] shared_io_tach_o,
  output logic [svmx_pkg::NUM_SHARED-1:0] shared_io_tach_oe,
  input wire logic [svmx_pkg::NUM_SHARED-1:0] tach_mode,
  input wire logic [svmx_pkg::NUM_SHARED-1:0] shared_pull_low,
  output logic [svmx_pkg::NUM_SHARED-1:0] shared_in_state,
  output logic [svmx_pkg::NUM_SHARED-1:0][svmx_pkg::TACH_W-1:0] tach_count,
  input wire logic [svmx_pkg::NUM_CPU-1:0] shared_io_trip_i,
  output logic [svmx_pkg::NUM_CPU-1:0] shared_io_trip_o,
  output logic [svmx_pkg::NUM_CPU-1:0] shared_io_trip_oe,
  input wire logic [svmx_pkg::NUM_CPU-1:0] trip_mode,
  input wire logic [svmx_pkg::NUM_CPU-1:0] trip_pull_low,
  input wire logic [svmx_pkg::NUM_CPU-1:0] processor_internal_error_n_i,
  output logic [svmx_pkg::NUM_CPU-1:0] processor_internal_error_n_o,
  output logic [svmx_pkg::NUM_CPU-1:0] processor_internal_error_n_oe,
  input wire logic [svmx_pkg::NUM_CPU-1:0] processor_internal_error_n_mode,
  input wire logic [svmx_pkg::NUM_CPU-1:0] processor_internal_error_n_pull_low,
  input wire logic regulator_hot_cpu_a,
  input wire logic regulator_hot_cpu_b,
  input wire logic term_fuse_chan_a,
  input wire logic term_fuse_chan_b,
  input wire logic [svmx_pkg::NUM_CPU-1:0] term_event_en,
  input wire logic [svmx_pkg::NUM_CPU-1:0] processor_throttle_signal,
  input wire logic [svmx_pkg::VID_W-1:0] voltage_id_input_a,
  input wire logic [svmx_pkg::VID_W-1:0] voltage_id_input_b,
  output logic [svmx_pkg::NUM_CPU-1:0][svmx_pkg::VID_W-1:0] vid_state,
  input wire logic [svmx_pkg::NUM_VOLT-1:0][svmx_pkg::DATA_W-1:0] volt_value,
  input wire logic [svmx_pkg::NUM_VOLT-1:0][svmx_pkg::DATA_W-1:0] volt_low,
  input wire logic [svmx_pkg::NUM_VOLT-1:0][svmx_pkg::DATA_W-1:0] volt_high,
  input wire logic [svmx_pkg::NUM_TEMP-1:0][svmx_pkg::TEMP_W-1:0] temp_value,
  input wire logic [svmx_pkg::NUM_TEMP-1:0][svmx_pkg::DATA_W-1:0] temp_low,
  input wire logic [svmx_pkg::NUM_TEMP-1:0][svmx_pkg::DATA_W-1:0] temp_high,
  input wire logic conv_valid,
  input wire logic limit_clear,
  output logic [svmx_pkg::NUM_VOLT-1:0] volt_status,
  output logic [svmx_pkg::NUM_TEMP-1:0] temp_status,
  output logic [svmx_pkg::NUM_TEMP-1:0][svmx_pkg::DATA_W-1:0] temp_report,
  input wire logic filter_en,
  input wire logic [svmx_pkg::TEMP_W-1:0] zone4_temp,
  input wire logic [svmx_pkg::NUM_ZONE-1:0] zone_sel_a,
  input wire logic [svmx_pkg::NUM_ZONE-1:0] zone_sel_b,
  input wire logic [svmx_pkg::TEMP_W-1:0] lut_base,
  input wire logic [svmx_pkg::TEMP_W-1:0] lut_step,
  input wire logic [svmx_pkg::LUT_STEPS-1:0][svmx_pkg::DATA_W-1:0] lut_duty,
  input wire logic [svmx_pkg::TEMP_W-1:0] boost_temp,
  output logic fan_drive_a_o,
  output logic fan_drive_a_oe,
  output logic fan_drive_b_o,
  output logic fan_drive_b_oe,
  output logic [svmx_pkg::NUM_CPU-1:0][svmx_pkg::DATA_W-1:0] fan_duty,
  input wire logic [svmx_pkg::NUM_EV-1:0] event_mask,
  input wire logic [svmx_pkg::NUM_EV-1:0] event_clear,
  output logic [svmx_pkg::NUM_EV-1:0] event_status,
  input wire logic xor_test_mode,
  output logic alert_or_xor_tree_out_o,
  output logic alert_or_xor_tree_out_oe,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic ext_reset_req,
  input wire logic [1:0] addr_sel_level,
  output logic [svmx_pkg::ADDR_W-1:0] slave_addr,
  input wire logic [svmx_pkg::DATA_W-1:0] smb_addr_byte,
  input wire logic smb_addr_valid,
  output logic smb_addr_hit,
  output logic smb_is_read
);
  import svmx_pkg::*;

  localparam int POR_W = $clog2(POR_CYCLES + 1);

  logic [NUM_SHARED-1:0] shared_prev_reg;
  logic [NUM_SHARED-1:0][TACH_W-1:0] tach_reg;
  logic [NUM_SHARED-1:0] shared_in_reg;
  logic [NUM_EV-1:0] ev_status_reg;
  logic [NUM_EV-1:0] ev_raw;
  logic [NUM_EV-1:0] ev_set;
  logic [NUM_CPU-1:0][VID_W-1:0] vid_reg;
  logic [NUM_CPU-1:0] trip_active;
  logic [POR_W-1:0] por_cnt_reg;
  logic por_done_reg;
  logic [NUM_TEMP-1:0][TEMP_W-1:0] filt_reg;
  logic [NUM_ZONE-1:0][TEMP_W-1:0] zone_temp;
  logic [NUM_CPU-1:0][DATA_W-1:0] duty_reg;
  logic [NUM_CPU-1:0][DATA_W-1:0] duty_next;
  logic [$clog2(PWM_DIV)-1:0] pwm_div_reg;
  logic [DATA_W-1:0] pwm_cnt_reg;
  logic [NUM_CPU-1:0] pwm_high;
  logic xor_result;
  logic alert_active;
  logic [1:0] addr_low;
  logic [ADDR_W-1:0] addr_reg;
  logic addr_hit_reg;
  logic addr_rd_reg;

  // Shared tach / general I/O pins
  assign shared_io_tach_o = '0;
  assign shared_io_tach_oe = shared_pull_low & ~tach_mode;
  assign shared_in_state = shared_in_reg;
  assign tach_count = tach_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shared_prev_reg <= '0;
      shared_in_reg <= '0;
      tach_reg <= '0;
    end else begin
      shared_prev_reg <= shared_io_tach_i;
      shared_in_reg <= shared_io_tach_i;
      for (int i = 0; i < NUM_SHARED; i++) begin
        if (tach_mode[i] && shared_prev_reg[i] && !shared_io_tach_i[i]) begin
          tach_reg[i] <= tach_reg[i] + 8'h01;
        end
      end
    end
  end

  // Trip and internal-error pins, both active low
  assign shared_io_trip_o = '0;
  assign shared_io_trip_oe = trip_pull_low & ~trip_mode;
  assign processor_internal_error_n_o = '0;
  assign processor_internal_error_n_oe = processor_internal_error_n_pull_low & ~processor_internal_error_n_mode;
  assign trip_active = trip_mode & ~shared_io_trip_i;

  // Voltage-id sampling
  assign vid_state = vid_reg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vid_reg <= '0;
    end else begin
      vid_reg[0] <= voltage_id_input_a;
      vid_reg[1] <= voltage_id_input_b;
    end
  end

  // Raw error events
  always_comb begin
    ev_raw = '0;
    ev_raw[EV_VOLT] = |volt_status;
    ev_raw[EV_TEMP] = |temp_status;
    ev_raw[EV_VRHOT_A] = regulator_hot_cpu_a;
    ev_raw[EV_VRHOT_B] = regulator_hot_cpu_b;
    ev_raw[EV_TERM_A] = term_event_en[0] & term_fuse_chan_a;
    ev_raw[EV_TERM_B] = term_event_en[1] & term_fuse_chan_b;
    ev_raw[EV_PROCESSOR_INTERNAL_ERROR_N_A] = processor_internal_error_n_mode[0] & ~processor_internal_error_n_i[0];
    ev_raw[EV_PROCESSOR_INTERNAL_ERROR_N_B] = processor_internal_error_n_mode[1] & ~processor_internal_error_n_i[1];
    ev_raw[EV_THROT_A] = processor_throttle_signal[0];
    ev_raw[EV_THROT_B] = processor_throttle_signal[1];
    ev_raw[EV_VID_A] = (voltage_id_input_a != vid_reg[0]);
    ev_raw[EV_VID_B] = (voltage_id_input_b != vid_reg[1]);
    ev_raw[EV_TRIP_A] = trip_active[0];
    ev_raw[EV_TRIP_B] = trip_active[1];
  end

  // An active trip lets only trip events through
  assign ev_set = (|trip_active) ? (ev_raw & EV_TRIP_SET) : ev_raw;
  assign event_status = ev_status_reg;

  // Sticky status; a new event wins over a clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ev_status_reg <= '0;
    end else begin
      ev_status_reg <= (ev_status_reg & ~event_clear) | ev_set;
    end
  end

  // Alert pin, reused as XOR-tree output in test mode
  assign xor_result = ^{shared_io_tach_i, shared_io_trip_i,
                        processor_internal_error_n_i, regulator_hot_cpu_a,
                        regulator_hot_cpu_b, term_fuse_chan_a,
                        term_fuse_chan_b, processor_throttle_signal,
                        voltage_id_input_a, voltage_id_input_b,
                        reset_pin_i};
  assign alert_active = |(ev_status_reg & ~event_mask);
  assign alert_or_xor_tree_out_o = 1'b0;
  assign alert_or_xor_tree_out_oe = xor_test_mode ? ~xor_result
                                                  : alert_active;

  // Power-up reset pulse, then the pin becomes an input
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt_reg <= '0;
      por_done_reg <= 1'b0;
    end else if (!por_done_reg) begin
      if (por_cnt_reg == POR_W'(POR_CYCLES - 1)) begin
        por_done_reg <= 1'b1;
      end else begin
        por_cnt_reg <= por_cnt_reg + 1'b1;
      end
    end
  end

  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = ~por_done_reg;
  assign ext_reset_req = por_done_reg & ~reset_pin_i;

  // Limit comparators, one per monitored value
  for (genvar v = 0; v < NUM_VOLT; v++) begin : g_volt
    svmx_limit_cmp #(.W(DATA_W)) u_cmp (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .value(volt_value[v]),
      .value_valid(conv_valid),
      .limit_low(volt_low[v]),
      .limit_high(volt_high[v]),
      .flag_clear(limit_clear),
      .flag(volt_status[v])
    );
  end

  for (genvar t = 0; t < NUM_TEMP; t++) begin : g_temp
    svmx_limit_cmp #(.W(DATA_W)) u_cmp (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .value(temp_report[t]),
      .value_valid(conv_valid),
      .limit_low(temp_low[t]),
      .limit_high(temp_high[t]),
      .flag_clear(limit_clear),
      .flag(temp_status[t])
    );
    assign temp_report[t] = temp_value[t][TEMP_W-1:1];
  end

  // Temperature filter for fan control
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      filt_reg <= '0;
    end else if (conv_valid) begin
      for (int t = 0; t < NUM_TEMP; t++) begin
        if (filter_en) begin
          filt_reg[t] <= TEMP_W'(({2'b00, filt_reg[t]} * 11'h003
                         + {2'b00, temp_value[t]}) >> 2);
        end else begin
          filt_reg[t] <= temp_value[t];
        end
      end
    end
  end

  assign zone_temp = {zone4_temp, filt_reg[2], filt_reg[1], filt_reg[0]};

  // Lookup-table duty per fan output
  always_comb begin
    logic [TEMP_W-1:0] hot;
    logic [NUM_ZONE-1:0] sel;
    logic [TEMP_W+3:0] thr;
    logic [3:0] idx;
    duty_next = '0;
    hot = '0;
    sel = '0;
    thr = '0;
    idx = '0;
    for (int f = 0; f < NUM_CPU; f++) begin
      sel = (f == 0) ? zone_sel_a : zone_sel_b;
      hot = '0;
      for (int z = 0; z < NUM_ZONE; z++) begin
        if (sel[z] && zone_temp[z] > hot) begin
          hot = zone_temp[z];
        end
      end
      idx = '0;
      for (int s = 0; s < LUT_STEPS; s++) begin
        thr = {4'h0, lut_base} + 13'(s) * {4'h0, lut_step};
        if ({4'h0, hot} >= thr) begin
          idx = 4'(s + 1);
        end
      end
      if (sel != '0 && hot >= boost_temp) begin
        duty_next[f] = DUTY_FULL;
      end else if (sel == '0 || idx == 4'h0) begin
        duty_next[f] = DUTY_IDLE;
      end else begin
        duty_next[f] = lut_duty[idx - 4'h1];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      duty_reg <= '0;
    end else begin
      duty_reg <= duty_next;
    end
  end

  // PWM generation
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pwm_div_reg <= '0;
      pwm_cnt_reg <= '0;
    end else begin
      pwm_div_reg <= pwm_div_reg + 1'b1;
      if (pwm_div_reg == '1) begin
        pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      end
    end
  end

  for (genvar f = 0; f < NUM_CPU; f++) begin : g_pwm
    assign pwm_high[f] = (duty_reg[f] == DUTY_FULL) ||
                         (pwm_cnt_reg < duty_reg[f]);
  end

  assign fan_duty = duty_reg;
  assign fan_drive_a_o = 1'b0;
  assign fan_drive_b_o = 1'b0;
  assign fan_drive_a_oe = ~pwm_high[0];
  assign fan_drive_b_oe = ~pwm_high[1];

  // Slave address from the select pin, and address-phase match
  always_comb begin
    case (addr_sel_level)
      ASEL_LOW: addr_low = 2'h0;
      ASEL_MID: addr_low = 2'h1;
      ASEL_HIGH: addr_low = 2'h2;
      default: addr_low = 2'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_reg <= SLAVE_ADDR_BASE;
      addr_hit_reg <= 1'b0;
      addr_rd_reg <= 1'b0;
    end else begin
      addr_reg <= {SLAVE_ADDR_BASE[6:2], addr_low};
      addr_hit_reg <= smb_addr_valid &&
                      smb_addr_byte[7:1] == addr_reg;
      addr_rd_reg <= smb_addr_valid && smb_addr_byte[0];
    end
  end

  assign slave_addr = addr_reg;
  assign smb_addr_hit = addr_hit_reg;
  assign smb_is_read = addr_rd_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_MASK_NO_ALERT: assert property (
    (!xor_test_mode && (ev_status_reg & ~event_mask) == '0)
      |-> !alert_or_xor_tree_out_oe)
    else $error("alert driven by masked events only");
  AST_ALERT_ON_EVENT: assert property (
    (!xor_test_mode && $past(resetn) && |($past(ev_set) & ~event_mask))
      |-> alert_or_xor_tree_out_oe)
    else $error("unmasked event did not raise alert");
  AST_XOR_MODE: assert property (
    xor_test_mode |-> alert_or_xor_tree_out_oe == ~xor_result)
    else $error("alert pin not carrying xor tree");
  AST_TRIP_MASKS: assert property (
    (|trip_active && ev_status_reg == '0 && event_clear == '0)
      |=> (ev_status_reg & ~EV_TRIP_SET) == '0)
    else $error("event passed while trip active");
  AST_SET_WINS: assert property (
    (term_event_en[0] && term_fuse_chan_a && !(|trip_active))
      |=> ev_status_reg[EV_TERM_A])
    else $error("fuse event lost");
  AST_POR_RELEASE: assert property (
    $rose(por_done_reg) |-> !reset_pin_oe && $past(reset_pin_oe))
    else $error("reset pin not released after pulse");
  AST_POR_HOLD: assert property (
    (por_cnt_reg < POR_W'(POR_CYCLES - 1)) |-> reset_pin_oe)
    else $error("reset pin released early");
  AST_ADDR_LOW: assert property (
    $stable(addr_sel_level) && addr_sel_level == ASEL_MID
      |=> slave_addr[1:0] == 2'h1)
    else $error("address low bits wrong");
  AST_NO_HIGH: assert property (
    !fan_drive_a_o && !fan_drive_b_o && !reset_pin_o &&
    !alert_or_xor_tree_out_o && shared_io_tach_o == '0)
    else $error("open-drain pin driven high");
  AST_TACH_GPIO: assert property (
    (shared_io_tach_oe & tach_mode) == '0)
    else $error("tach pin driven in tach mode");
  AST_FULL_DUTY: assert property (
    duty_reg[0] == DUTY_FULL |-> !fan_drive_a_oe)
    else $error("full duty not held released");

  COV_ALERT: cover property ($rose(alert_or_xor_tree_out_oe));
  COV_TRIP: cover property (|trip_active ##1 |ev_status_reg);
  COV_POR: cover property ($rose(por_done_reg));
  COV_HIT: cover property (smb_addr_hit);
endmodule

// ### rtl/svmx_limit_cmp.sv
// Window comparator with a sticky out-of-limit flag.
// Assumes value, limits and clear are synchronous to sys_clk.
`timescale 1ns/1ns
module svmx_limit_cmp #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] value,
  input wire logic value_valid,
  input wire logic [W-1:0] limit_low,
  input wire logic [W-1:0] limit_high,
  input wire logic flag_clear,
  output logic flag
);
  logic flag_reg;
  logic out_of_range;

  assign out_of_range = value_valid &&
                        (value < limit_low || value > limit_high);
  assign flag = flag_reg;

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (out_of_range) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  AST_CMP_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
    out_of_range |=> flag_reg)
    else $error("limit flag not set after excursion");
endmodule

// ### rtl/svmx_pkg.sv
// Shared constants for the server monitor event and pin-function block.
// Assumes a single 50 MHz system clock and an active-low async reset.
package svmx_pkg;
  localparam int NUM_SHARED = 4;
  localparam int NUM_CPU = 2;
  localparam int NUM_VOLT = 16;
  localparam int NUM_TEMP = 3;
  localparam int NUM_ZONE = 4;
  localparam int LUT_STEPS = 13;
  localparam int VID_W = 6;
  localparam int DATA_W = 8;
  localparam int TEMP_W = 9;
  localparam int TACH_W = 8;
  localparam int ADDR_W = 7;
  // Upper five address bits; the low two come from the select pin
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h2C;
  // Decoded levels of the three-level address-select pin
  localparam logic [1:0] ASEL_LOW = 2'h0;
  localparam logic [1:0] ASEL_MID = 2'h1;
  localparam logic [1:0] ASEL_HIGH = 2'h2;
  // Event vector positions
  localparam int EV_VOLT = 0;
  localparam int EV_TEMP = 1;
  localparam int EV_VRHOT_A = 2;
  localparam int EV_VRHOT_B = 3;
  localparam int EV_TERM_A = 4;
  localparam int EV_TERM_B = 5;
  localparam int EV_PROCESSOR_INTERNAL_ERROR_N_A = 6;
  localparam int EV_PROCESSOR_INTERNAL_ERROR_N_B = 7;
  localparam int EV_THROT_A = 8;
  localparam int EV_THROT_B = 9;
  localparam int EV_VID_A = 10;
  localparam int EV_VID_B = 11;
  localparam int EV_TRIP_A = 12;
  localparam int EV_TRIP_B = 13;
  localparam int NUM_EV = 14;
  localparam logic [NUM_EV-1:0] EV_TRIP_SET = 14'h3000;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int POR_PULSE_US = 100;
  localparam int PWM_DIV = 4;
  localparam logic [DATA_W-1:0] DUTY_FULL = 8'hFF;
  localparam logic [DATA_W-1:0] DUTY_IDLE = 8'h00;
endpackage

// ### testbench/svmx_pin_host.sv
// Outside world of the open-drain pins: pull-ups plus outside pull-downs.
// Assumes bit i of each vector belongs to one and the same pin.
`timescale 1ns/1ns
module svmx_pin_host (
  input wire logic [9:0] dut_o,
  input wire logic [9:0] dut_oe,
  input wire logic [9:0] ext_low,
  output logic [9:0] level
);
  // Wired-AND with pull-up; a driven-high pin shows as high
  assign level = (dut_oe & dut_o) | ~(dut_oe | ext_low);
endmodule

// ### testbench/tb.sv
// Self-checking bench for the event, pin, fan and address logic.
// Assumes the pin model resolves all open-drain lines but the fan drives, which are read from their _oe outputs.
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0;
  logic resetn, regulator_hot_cpu_a, regulator_hot_cpu_b, term_fuse_chan_a;
  logic term_fuse_chan_b, conv_valid, limit_clear, filter_en, xor_test_mode;
  logic fan_drive_a_o, fan_drive_a_oe, fan_drive_b_o, fan_drive_b_oe;
  logic alert_or_xor_tree_out_o, alert_or_xor_tree_out_oe, reset_pin_i;
  logic reset_pin_o, reset_pin_oe, ext_reset_req, smb_addr_valid;
  logic smb_addr_hit, smb_is_read;
  logic [3:0] shared_io_tach_i, shared_io_tach_o, shared_io_tach_oe;
  logic [3:0] tach_mode, shared_pull_low, shared_in_state;
  logic [3:0] zone_sel_a, zone_sel_b;
  logic [1:0] shared_io_trip_i, shared_io_trip_o, shared_io_trip_oe;
  logic [1:0] trip_mode, trip_pull_low, processor_internal_error_n_mode, processor_internal_error_n_pull_low;
  logic [1:0] processor_internal_error_n_i, processor_internal_error_n_o;
  logic [1:0] processor_internal_error_n_oe, term_event_en, addr_sel_level;
  logic [1:0] processor_throttle_signal;
  logic [3:0][7:0] tach_count;
  logic [5:0] voltage_id_input_a, voltage_id_input_b;
  logic [1:0][5:0] vid_state;
  logic [15:0][7:0] volt_value, volt_low, volt_high;
  logic [2:0][8:0] temp_value;
  logic [2:0][7:0] temp_low, temp_high, temp_report;
  logic [15:0] volt_status;
  logic [2:0] temp_status;
  logic [8:0] zone4_temp, lut_base, lut_step, boost_temp;
  logic [12:0][7:0] lut_duty;
  logic [1:0][7:0] fan_duty;
  logic [13:0] event_mask, event_clear, event_status;
  logic [6:0] slave_addr;
  logic [7:0] smb_addr_byte;
  logic [9:0] ext_low, lvl;
  int n_errors = 0;
  int checks = 0;

  svmx_event_io #(.POR_CYCLES(8)) DUT (.*);
  svmx_pin_host pins (
    .dut_o({reset_pin_o, alert_or_xor_tree_out_o,
      processor_internal_error_n_o, shared_io_trip_o, shared_io_tach_o}),
    .dut_oe({reset_pin_oe, alert_or_xor_tree_out_oe,
      processor_internal_error_n_oe, shared_io_trip_oe, shared_io_tach_oe}),
    .ext_low(ext_low),
    .level(lvl)
  );
  assign {reset_pin_i, processor_internal_error_n_i, shared_io_trip_i,
    shared_io_tach_i} = {lvl[9], lvl[7:0]};

  always #10 sys_clk = ~sys_clk;

  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task stop_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task ev_clr;
    event_clear = '1;
    cyc(1);
    event_clear = '0;
    cyc(1);
  endtask

  task conv;
    conv_valid = 1'b1;
    cyc(1);
    conv_valid = 1'b0;
    cyc(3);
  endtask

  task t_por;
    cyc(6);
    chk(reset_pin_oe, 1);
    cyc(4);
    chk({reset_pin_oe, lvl[9]}, 2'b01);
    ext_low[9] = 1'b1;
    cyc(1);
    chk(ext_reset_req, 1);
    ext_low[9] = 1'b0;
  endtask

  task t_pins;
    {shared_pull_low, trip_pull_low, processor_internal_error_n_pull_low} = '1;
    cyc(1);
    chk(lvl[7:0], 8'h00);
    {tach_mode, trip_mode, processor_internal_error_n_mode} = '1;
    cyc(1);
    chk(lvl[7:0], 8'hFF);
    repeat (2) begin
      ext_low[0] = 1'b1;
      cyc(2);
      ext_low[0] = 1'b0;
      cyc(2);
    end
    chk(tach_count[1:0], 16'h0002);
    {shared_pull_low, trip_pull_low, processor_internal_error_n_pull_low, trip_mode} = '0;
  endtask

  task t_evt;
    ev_clr();
    term_event_en = 2'b01;
    term_fuse_chan_a = 1'b1;
    cyc(2);
    chk({event_status[4], alert_or_xor_tree_out_oe}, 2'b11);
    chk(lvl[8], 0);
    event_mask[4] = 1'b1;
    term_fuse_chan_a = 1'b0;
    ev_clr();
    term_fuse_chan_a = 1'b1;
    cyc(2);
    chk({event_status[4], alert_or_xor_tree_out_oe}, 2'b10);
    regulator_hot_cpu_a = 1'b1;
    cyc(2);
    chk({event_status[2], alert_or_xor_tree_out_oe}, 2'b11);
    {term_fuse_chan_a, regulator_hot_cpu_a, event_mask} = '0;
    ev_clr();
    chk(alert_or_xor_tree_out_oe, 0);
  endtask

  task t_trip;
    trip_mode = 2'b01;
    ext_low[4] = 1'b1;
    cyc(2);
    {term_fuse_chan_a, regulator_hot_cpu_b} = 2'b11;
    cyc(2);
    chk(event_status, 14'h1000);
    ext_low[4] = 1'b0;
    cyc(3);
    chk(event_status[4:3], 2'b11);
    {term_fuse_chan_a, regulator_hot_cpu_b, trip_mode} = '0;
    ev_clr();
  endtask

  task t_vid;
    voltage_id_input_a = 6'h15;
    processor_throttle_signal = 2'b10;
    ext_low[6] = 1'b1;
    cyc(2);
    chk({vid_state[0], event_status[10:8]}, 9'h0AE);
    chk(event_status[7:6], 2'b01);
    processor_throttle_signal = 2'b00;
    ext_low[6] = 1'b0;
    ev_clr();
  endtask

  task t_addr;
    for (int i = 0; i < 4; i++) begin
      addr_sel_level = i[1:0];
      cyc(2);
      chk(slave_addr, 7'h2C | (i == 3 ? 0 : i));
      smb_addr_byte = {slave_addr, 1'b1};
      smb_addr_valid = 1'b1;
      cyc(1);
      smb_addr_valid = 1'b0;
      chk({smb_addr_hit, smb_is_read}, 2'b11);
    end
    cyc(1);
    smb_addr_byte = 8'h58;
    smb_addr_valid = 1'b1;
    cyc(1);
    smb_addr_valid = 1'b0;
    chk({smb_addr_hit, smb_is_read}, 2'b10);
    cyc(1);
    smb_addr_byte = 8'h00;
    smb_addr_valid = 1'b1;
    cyc(1);
    smb_addr_valid = 1'b0;
    chk(smb_addr_hit, 0);
  endtask

  task t_limit;
    {volt_value[0], volt_high[0], volt_low[5]} = 24'h908020;
    {temp_value[1], temp_high[1]} = {9'h0A3, 8'h40};
    cyc(1);
    chk(temp_report[1], 8'h51);
    conv();
    chk({volt_status, temp_status}, 19'h0010A);
    chk(event_status[1:0], 2'b11);
    limit_clear = 1'b1;
    cyc(1);
    limit_clear = 1'b0;
    cyc(1);
    chk(volt_status, 0);
  endtask

  task t_fan;
    int n;
    {lut_base, boost_temp, zone_sel_a, zone_sel_b} = {18'h200C0, 8'h12};
    lut_duty = {13{8'h40}};
    {temp_value[0], temp_value[1]} = {9'h150, 9'h080};
    conv();
    chk(fan_duty, 16'h00FF);
    repeat (8) begin
      cyc(1);
      chk({fan_drive_a_oe, fan_drive_b_oe}, 2'b01);
    end
    {boost_temp, zone_sel_a, filter_en} = {9'h1F0, 5'h01};
    temp_value[1] = 9'h180;
    for (int k = 0; k < 3; k++) begin
      conv();
      chk(fan_duty[1], k == 2 ? 8'h40 : 8'h00);
    end
    n = 0;
    repeat (1024) begin
      cyc(1);
      if (!fan_drive_b_oe) begin
        n++;
      end
    end
    chk(n, 32'h100);
  endtask

  task t_xor;
    logic x0;
    xor_test_mode = 1'b1;
    cyc(1);
    x0 = lvl[8];
    regulator_hot_cpu_a = ~regulator_hot_cpu_a;
    cyc(1);
    chk(lvl[8], !x0);
    ext_low[0] = 1'b1;
    cyc(1);
    chk(lvl[8], x0);
    {xor_test_mode, regulator_hot_cpu_a, ext_low[0]} = '0;
    ev_clr();
  endtask

  initial begin
    {resetn, regulator_hot_cpu_a, regulator_hot_cpu_b, term_fuse_chan_a,
      term_fuse_chan_b, conv_valid, limit_clear, filter_en, xor_test_mode,
      smb_addr_valid, tach_mode, shared_pull_low, zone_sel_a, zone_sel_b,
      trip_mode, trip_pull_low, processor_internal_error_n_mode, processor_internal_error_n_pull_low, term_event_en,
      addr_sel_level, processor_throttle_signal, voltage_id_input_a,
      voltage_id_input_b, volt_value, volt_low, volt_high, temp_value,
      temp_low, temp_high, zone4_temp, lut_base, lut_step, boost_temp,
      lut_duty, event_mask, event_clear, smb_addr_byte, ext_low} = '0;
    cyc(5);
    resetn = 1'b1;
    t_por();
    t_pins();
    t_evt();
    t_trip();
    t_vid();
    t_addr();
    t_limit();
    t_fan();
    t_xor();
    stop_test();
  end

  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule
